/* File: pkg/hub_cfg_pkg.sv */
// Register map, field layout and reset values of the hub configuration bank
package hub_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int STR_MAX_CHARS = 31;
  localparam int STR_BYTES = 62;
  localparam int STR_IDX_W = 6;
  localparam int CHAR_IDX_W = 5;
  localparam int NUM_PORTS = 4;

  localparam logic [7:0] PRODUCT_LEN_ADDR = 8'h14;
  localparam logic [7:0] SERIAL_LEN_ADDR = 8'h15;
  localparam logic [7:0] PRODUCT_STR_FIRST = 8'h54;
  localparam logic [7:0] PRODUCT_STR_LAST = 8'h91;
  localparam logic [7:0] SERIAL_STR_FIRST = 8'h92;
  localparam logic [7:0] SERIAL_STR_LAST = 8'hCF;
  localparam logic [7:0] CHARGE_ENABLE_ADDR = 8'hD0;
  localparam logic [7:0] DRIVE_STRENGTH_ADDR = 8'hF6;

  localparam int CHARGE_LSB = 1;
  localparam int CHARGE_MSB = 4;
  localparam int DRIVE_LSB = 0;
  localparam int DRIVE_MSB = 1;

  localparam logic [7:0] LEN_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] CHARGE_RESET = 4'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [4:0] MAX_CHARS_5 = 5'h1F;

  typedef enum logic [1:0] {
    DRIVE_NONE,
    DRIVE_LOW,
    DRIVE_MEDIUM,
    DRIVE_HIGH
  } drive_level_e;

  // True when addr lies within first..last inclusive
  function automatic logic in_region(input logic [7:0] addr, input logic [7:0] first,
                                     input logic [7:0] last);
    return (addr >= first) && (addr <= last);
  endfunction

  // Number of valid characters, limited to the string capacity
  function automatic logic [4:0] clamp_count(input logic [7:0] len);
    return (len > 8'(STR_MAX_CHARS)) ? MAX_CHARS_5 : len[4:0];
  endfunction

endpackage

/* File: rtl/string_store.sv */
// One descriptor string held as 62 bytes with a character read port
`timescale 1ns/10ps
`default_nettype none
module string_store
  import hub_cfg_pkg::*;
#(
  parameter int BYTES = STR_BYTES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [STR_IDX_W-1:0] wr_index,
  input wire logic [7:0] wr_data,
  input wire logic [STR_IDX_W-1:0] rd_index,
  output logic [7:0] rd_byte,
  input wire logic [7:0] length,
  input wire logic [CHAR_IDX_W-1:0] char_index,
  output logic [15:0] char_data,
  output logic char_valid,
  output logic [CHAR_IDX_W-1:0] char_count
);

  logic [7:0] mem_q [BYTES];
  logic [15:0] char_data_q;
  logic char_valid_q;
  logic [STR_IDX_W-1:0] lo_idx;
  logic [STR_IDX_W-1:0] hi_idx;

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < BYTES; i++) begin
        mem_q[i] <= BYTE_RESET;
      end
    end else if (wr_en && (int'(wr_index) < BYTES)) begin
      mem_q[wr_index] <= wr_data;
    end
  end

  assign rd_byte = (int'(rd_index) < BYTES) ? mem_q[rd_index] : UNMAPPED_READ;
  assign char_count = clamp_count(length); // R9 R3
  assign lo_idx = {char_index, 1'b0};
  assign hi_idx = {char_index, 1'b1};

  // Low byte at the even address, high byte at the next one
  always_ff @(posedge clock) begin
    if (reset) begin
      char_data_q <= 16'h0000;
      char_valid_q <= 1'b0;
    end else begin
      char_valid_q <= char_index < char_count; // R9
      if (int'(hi_idx) < BYTES) begin
        char_data_q <= {mem_q[hi_idx], mem_q[lo_idx]}; // R4
      end else begin
        char_data_q <= 16'h0000;
      end
    end
  end

  assign char_data = char_data_q;
  assign char_valid = char_valid_q;

endmodule
`default_nettype wire

/* File: rtl/hub_string_charge_boost_cfg.sv */
// Hub configuration bank: descriptor strings, charging enables, upstream drive
//
// Summary of operation
// R1: Product string bytes live at 0x54-0x91
// R2: Serial string bytes live at 0x92-0xCF
// R3: Each string holds at most 31 characters
// R4: Writer stores characters low byte first
// R5: Bits 1-4 at 0xD0 enable port charging
// R6: Reserved charge bits control no port
// R7: Bits 1:0 at 0xF6 select upstream boost
// R8: Writer should keep boost at zero; the bench writes every level 0-3 to 0xF6, then writes 0 back
// R9: Length registers set valid character count
// R10: Reserved bits ignored, read back zero
`timescale 1ns/10ps
`default_nettype none
module hub_string_charge_boost_cfg
  import hub_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [ADDR_W-1:0] cfg_addr,
  input wire logic [DATA_W-1:0] cfg_wdata,
  output logic [DATA_W-1:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic [CHAR_IDX_W-1:0] product_char_index,
  output logic [15:0] product_char,
  output logic product_char_valid,
  output logic [CHAR_IDX_W-1:0] product_string_count,
  input wire logic [CHAR_IDX_W-1:0] serial_char_index,
  output logic [15:0] serial_char,
  output logic serial_char_valid,
  output logic [CHAR_IDX_W-1:0] serial_string_count,
  output logic [NUM_PORTS-1:0] charge_port_on,
  output logic [1:0] upstream_drive_level
);

  logic [7:0] product_string_length_q;
  logic [7:0] serial_string_length_q;
  logic [NUM_PORTS-1:0] charge_port_enable_q;
  drive_level_e upstream_drive_strength_q;
  logic [DATA_W-1:0] rdata_q;
  logic rvalid_q;
  logic [DATA_W-1:0] rd_mux;
  logic product_hit;
  logic serial_hit;
  logic [STR_IDX_W-1:0] product_idx;
  logic [STR_IDX_W-1:0] serial_idx;
  logic [7:0] product_rd_byte;
  logic [7:0] serial_rd_byte;
  logic [7:0] product_off;
  logic [7:0] serial_off;

  assign product_hit = in_region(cfg_addr, PRODUCT_STR_FIRST, PRODUCT_STR_LAST); // R1
  assign serial_hit = in_region(cfg_addr, SERIAL_STR_FIRST, SERIAL_STR_LAST); // R2
  assign product_off = cfg_addr - PRODUCT_STR_FIRST;
  assign serial_off = cfg_addr - SERIAL_STR_FIRST;
  assign product_idx = product_off[STR_IDX_W-1:0];
  assign serial_idx = serial_off[STR_IDX_W-1:0];

  string_store #(
    .BYTES(STR_BYTES)
  ) product_store (
    .clock(clock),
    .reset(reset),
    .wr_en(cfg_write && product_hit), // R1
    .wr_index(product_idx),
    .wr_data(cfg_wdata),
    .rd_index(product_idx),
    .rd_byte(product_rd_byte),
    .length(product_string_length_q),
    .char_index(product_char_index),
    .char_data(product_char),
    .char_valid(product_char_valid),
    .char_count(product_string_count)
  );

  string_store #(
    .BYTES(STR_BYTES)
  ) serial_store (
    .clock(clock),
    .reset(reset),
    .wr_en(cfg_write && serial_hit), // R2
    .wr_index(serial_idx),
    .wr_data(cfg_wdata),
    .rd_index(serial_idx),
    .rd_byte(serial_rd_byte),
    .length(serial_string_length_q),
    .char_index(serial_char_index),
    .char_data(serial_char),
    .char_valid(serial_char_valid),
    .char_count(serial_string_count)
  );

  // Length registers
  always_ff @(posedge clock) begin
    if (reset) begin
      product_string_length_q <= LEN_RESET;
      serial_string_length_q <= LEN_RESET;
    end else if (cfg_write) begin
      if (cfg_addr == PRODUCT_LEN_ADDR) begin
        product_string_length_q <= cfg_wdata; // R9
      end
      if (cfg_addr == SERIAL_LEN_ADDR) begin
        serial_string_length_q <= cfg_wdata; // R9
      end
    end
  end

  // Charging enables, only port bits stored
  always_ff @(posedge clock) begin
    if (reset) begin
      charge_port_enable_q <= CHARGE_RESET;
    end else if (cfg_write && (cfg_addr == CHARGE_ENABLE_ADDR)) begin
      charge_port_enable_q <= cfg_wdata[CHARGE_MSB:CHARGE_LSB]; // R5 R6 R10
    end
  end

  // Upstream drive strength, only the 2-bit field stored
  always_ff @(posedge clock) begin
    if (reset) begin
      upstream_drive_strength_q <= DRIVE_NONE;
    end else if (cfg_write && (cfg_addr == DRIVE_STRENGTH_ADDR)) begin
      upstream_drive_strength_q <= drive_level_e'(cfg_wdata[DRIVE_MSB:DRIVE_LSB]); // R7 R10
    end
  end

  assign charge_port_on = charge_port_enable_q; // R5
  assign upstream_drive_level = upstream_drive_strength_q; // R7

  // Read decode, reserved and unmapped bits read as zero
  always_comb begin
    rd_mux = UNMAPPED_READ;
    if (product_hit) begin
      rd_mux = product_rd_byte;
    end else if (serial_hit) begin
      rd_mux = serial_rd_byte;
    end else begin
      case (cfg_addr)
        PRODUCT_LEN_ADDR: rd_mux = product_string_length_q;
        SERIAL_LEN_ADDR: rd_mux = serial_string_length_q;
        CHARGE_ENABLE_ADDR: rd_mux = {3'h0, charge_port_enable_q, 1'b0}; // R10
        DRIVE_STRENGTH_ADDR: rd_mux = {6'h00, upstream_drive_strength_q}; // R10
        default: rd_mux = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= UNMAPPED_READ;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cfg_read;
      if (cfg_read) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_product_store_read: assert property ( // R1
    (cfg_write && cfg_addr == PRODUCT_STR_FIRST) ##1
    (cfg_read && !cfg_write && cfg_addr == PRODUCT_STR_FIRST)
    |=> cfg_rvalid && cfg_rdata == $past(cfg_wdata, 2))
    else $error("product string byte not returned");
  a_serial_store_read: assert property ( // R2
    (cfg_write && cfg_addr == SERIAL_STR_LAST) ##1
    (cfg_read && !cfg_write && cfg_addr == SERIAL_STR_LAST)
    |=> cfg_rvalid && cfg_rdata == $past(cfg_wdata, 2))
    else $error("serial string byte not returned");
  a_count_clamped: assert property ( // R3
    product_string_count <= MAX_CHARS_5 && serial_string_count <= MAX_CHARS_5 &&
    (product_string_length_q > 8'(STR_MAX_CHARS) -> product_string_count == MAX_CHARS_5))
    else $error("string count exceeds capacity");
  a_charge_update: assert property ( // R5
    cfg_write && cfg_addr == CHARGE_ENABLE_ADDR
    |=> charge_port_on == $past(cfg_wdata[CHARGE_MSB:CHARGE_LSB]))
    else $error("charge enables not updated");
  a_charge_hold: assert property ( // R6
    !(cfg_write && cfg_addr == CHARGE_ENABLE_ADDR) |=> $stable(charge_port_on))
    else $error("charge enables changed without write");
  a_drive_update: assert property ( // R7
    cfg_write && cfg_addr == DRIVE_STRENGTH_ADDR
    |=> upstream_drive_level == $past(cfg_wdata[DRIVE_MSB:DRIVE_LSB]))
    else $error("drive level not updated");
  a_product_valid: assert property ( // R9
    1'b1 |=> product_char_valid == ($past(product_char_index) < $past(product_string_count)))
    else $error("product character valid wrong");
  a_serial_valid: assert property ( // R9
    1'b1 |=> serial_char_valid == ($past(serial_char_index) < $past(serial_string_count)))
    else $error("serial character valid wrong");
  a_reserved_zero: assert property ( // R10
    cfg_read && (cfg_addr == CHARGE_ENABLE_ADDR || cfg_addr == DRIVE_STRENGTH_ADDR)
    |=> cfg_rdata[7:5] == 3'h0 && (cfg_rdata[0] == 1'b0 || $past(cfg_addr) ==
    DRIVE_STRENGTH_ADDR) && ($past(cfg_addr) != DRIVE_STRENGTH_ADDR || cfg_rdata[4:2] == 3'h0))
    else $error("reserved bits read nonzero");
  a_drive_hold: assert property ( // R7
    !(cfg_write && cfg_addr == DRIVE_STRENGTH_ADDR) |=> $stable(upstream_drive_level))
    else $error("drive level changed without write");
  a_product_len_hold: assert property ( // R9
    !(cfg_write && cfg_addr == PRODUCT_LEN_ADDR) |=> $stable(product_string_count))
    else $error("product count changed without write");
  a_serial_len_hold: assert property ( // R9
    !(cfg_write && cfg_addr == SERIAL_LEN_ADDR) |=> $stable(serial_string_count))
    else $error("serial count changed without write");
  a_drive_readback: assert property ( // R10
    cfg_read && cfg_addr == DRIVE_STRENGTH_ADDR
    |=> cfg_rdata == {6'h00, $past(upstream_drive_level)})
    else $error("drive register read back wrong");

  c_charge_all: cover property (charge_port_on == 4'hF);
  c_drive_high: cover property (upstream_drive_level == 2'h3);
  c_product_char: cover property (product_char_valid && product_string_count == MAX_CHARS_5);
  c_serial_read: cover property (cfg_rvalid && $past(serial_hit));
  c_back_to_back: cover property (cfg_write ##1 cfg_read);

endmodule
`default_nettype wire

/* File: dv/cfg_writer.sv */
// Configuration writer model that drives the byte strobe port
`timescale 1ns/10ps
`default_nettype none
module cfg_writer (
  input wire logic clock,
  output logic cfg_write,
  output logic cfg_read,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata
);
  initial begin
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
  end
  // Released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cfg_write <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_write <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    cfg_read <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_read <= 1'b0;
    cfg_addr <= ~a;
    #1 d = cfg_rdata;
  endtask
  // Write a byte, then read it back on the very next edge
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    cfg_write <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_write <= 1'b0;
    cfg_read <= 1'b1;
    @(posedge clock);
    cfg_read <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
    #1 q = cfg_rdata;
  endtask
  // Low byte at the lower address, then the high byte
  task automatic put_char(input logic [7:0] b, input int i, input logic [15:0] c);
    wr(b + 8'(2 * i), c[7:0]);
    wr(b + 8'(2 * i + 1), c[15:8]);
  endtask
endmodule
`default_nettype wire

/* File: dv/test_hub_string_charge_boost_cfg.sv */
// Self-checking bench for the hub configuration bank
`timescale 1ns/10ps
`default_nettype none
module test_hub_string_charge_boost_cfg;
  import hub_cfg_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cfg_write;
  logic cfg_read;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic [4:0] product_char_index = 5'h00;
  logic [4:0] serial_char_index = 5'h00;
  logic [15:0] product_char;
  logic [15:0] serial_char;
  logic product_char_valid;
  logic serial_char_valid;
  logic [4:0] product_string_count;
  logic [4:0] serial_string_count;
  logic [3:0] charge_port_on;
  logic [1:0] upstream_drive_level;
  int mismatches = 0;
  int check_count = 0;
  always #5 clock = ~clock;
  cfg_writer u_cfg_writer (.clock(clock), .cfg_write(cfg_write), .cfg_read(cfg_read),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  hub_string_charge_boost_cfg u_hub_string_charge_boost_cfg (.clock(clock), .reset(reset),
    .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .product_char_index(product_char_index),
    .product_char(product_char), .product_char_valid(product_char_valid),
    .product_string_count(product_string_count), .serial_char_index(serial_char_index),
    .serial_char(serial_char), .serial_char_valid(serial_char_valid),
    .serial_string_count(serial_string_count), .charge_port_on(charge_port_on),
    .upstream_drive_level(upstream_drive_level));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_cfg_writer.rd(a, d);
    chk(16'(cfg_rvalid), 16'h0001);
    chk(16'(d), 16'(exp));
  endtask
  task automatic settle();
    @(posedge clock);
    #1;
  endtask
  task automatic chrchk(input logic s, input logic [4:0] i, input logic [15:0] c,
                        input logic v);
    @(posedge clock);
    if (s) begin
      serial_char_index <= i;
    end else begin
      product_char_index <= i;
    end
    repeat (2) @(posedge clock);
    #1;
    chk(s ? serial_char : product_char, c);
    chk(16'(s ? serial_char_valid : product_char_valid), 16'(v));
  endtask
  task automatic t_reset();
    chk(16'(charge_port_on), 16'h0000);
    chk(16'(upstream_drive_level), 16'h0000);
    chk(16'(product_string_count), 16'h0000);
    rdchk(CHARGE_ENABLE_ADDR, 8'h00);
  endtask
  task automatic t_charge();
    u_cfg_writer.wr(CHARGE_ENABLE_ADDR, 8'hFF);
    rdchk(CHARGE_ENABLE_ADDR, 8'h1E);
    chk(16'(charge_port_on), 16'h000F);
    u_cfg_writer.wr(CHARGE_ENABLE_ADDR, 8'hE1);
    settle();
    chk(16'(charge_port_on), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      u_cfg_writer.wr(CHARGE_ENABLE_ADDR, 8'(2 << k));
      settle();
      chk(16'(charge_port_on), 16'(1 << k));
    end
  endtask
  task automatic t_drive();
    for (int c = 0; c < 4; c++) begin
      u_cfg_writer.wr(DRIVE_STRENGTH_ADDR, 8'hFC | 8'(c));
      rdchk(DRIVE_STRENGTH_ADDR, 8'(c));
      chk(16'(upstream_drive_level), 16'(c));
    end
    u_cfg_writer.wr(DRIVE_STRENGTH_ADDR, 8'h00);
  endtask
  task automatic t_strings();
    u_cfg_writer.put_char(PRODUCT_STR_FIRST, 0, 16'h0041);
    u_cfg_writer.put_char(PRODUCT_STR_FIRST, 30, 16'hBEEF);
    u_cfg_writer.put_char(SERIAL_STR_FIRST, 0, 16'h1234);
    u_cfg_writer.put_char(SERIAL_STR_FIRST, 30, 16'hC0DE);
    u_cfg_writer.wr(8'h53, 8'h77);
    rdchk(8'h53, 8'h00);
    rdchk(PRODUCT_STR_LAST, 8'hBE);
    rdchk(SERIAL_STR_LAST, 8'hC0);
    u_cfg_writer.wr(PRODUCT_LEN_ADDR, 8'h28);
    u_cfg_writer.wr(SERIAL_LEN_ADDR, 8'h1F);
    rdchk(PRODUCT_LEN_ADDR, 8'h28);
    chk(16'(product_string_count), 16'h001F);
    chk(16'(serial_string_count), 16'h001F);
    chrchk(1'b0, 5'h00, 16'h0041, 1'b1);
    chrchk(1'b0, 5'h1E, 16'hBEEF, 1'b1);
    chrchk(1'b0, 5'h1F, 16'h0000, 1'b0);
    chrchk(1'b1, 5'h00, 16'h1234, 1'b1);
    chrchk(1'b1, 5'h1E, 16'hC0DE, 1'b1);
    u_cfg_writer.wr(PRODUCT_LEN_ADDR, 8'h01);
    chrchk(1'b0, 5'h00, 16'h0041, 1'b1);
    chrchk(1'b0, 5'h01, 16'h0000, 1'b0);
  endtask
  task automatic t_back_to_back();
    logic [7:0] q;
    u_cfg_writer.wrrd(PRODUCT_STR_FIRST, 8'h5A, q);
    chk(16'(q), 16'h005A);
    chk(16'(cfg_rvalid), 16'h0001);
    u_cfg_writer.wrrd(SERIAL_STR_LAST, 8'hA5, q);
    chk(16'(q), 16'h00A5);
  endtask
  task automatic end_of_test();
    $display("mismatches=%0d check_count=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #50000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_charge();
    t_drive();
    t_strings();
    t_back_to_back();
    end_of_test();
  end
endmodule
`default_nettype wire
